// ---- core/prd_pkg.sv ----
// Shared constants and types of the peripheral register decoder.
package prd_pkg;

  // ==========================================================
  // Word and window geometry
  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;
  localparam int IDX_W = 3;
  localparam int UNIT_N = 7;
  localparam int OFF_W = 6;
  localparam logic [9:0] WIN_TAG = 10'h0E0;

  // ==========================================================
  // Register addresses, identical in X and Y space
  localparam logic [15:0] A_SERIAL_DATA = 16'h3800;
  localparam logic [15:0] A_SERIAL_STATUS = 16'h3801;
  localparam logic [15:0] A_AUDIO_STATUS = 16'h3802;
  localparam logic [15:0] A_PORT_DATA = 16'h3804;
  localparam logic [15:0] A_PORT_CMD = 16'h3805;
  localparam logic [15:0] A_HOST_DATA = 16'h3806;
  localparam logic [15:0] A_HOST_STATUS = 16'h3807;
  localparam logic [15:0] A_CARD_DATA = 16'h3810;
  localparam logic [15:0] A_CARD_CMD_IDX = 16'h3811;
  localparam logic [15:0] A_CARD_ARG_HI = 16'h3812;
  localparam logic [15:0] A_CARD_ARG_LO = 16'h3813;
  localparam logic [15:0] A_CARD_CTRL = 16'h3814;
  localparam logic [15:0] A_CARD_RESP = 16'h3815;
  localparam logic [15:0] A_CARD_CRC_BUSY = 16'h3816;
  localparam logic [15:0] A_TMR_INIT = 16'h3820;
  localparam logic [15:0] A_TMR_COUNT = 16'h3821;
  localparam logic [15:0] A_TMR_CTRL = 16'h3822;
  localparam logic [15:0] A_TMR_ENABLE = 16'h3823;
  localparam logic [15:0] A_CLK_CTRL = 16'h382E;
  localparam logic [15:0] A_DMA_START = 16'h3830;
  localparam logic [15:0] A_DMA_SIZE = 16'h3831;
  localparam logic [15:0] A_DMA_PTR = 16'h3832;
  localparam logic [15:0] A_DMA_CTRL = 16'h3833;

  // ==========================================================
  // Reset values of the decoder's own state
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [6:0] RST_SEL = 7'h00;

  // ==========================================================
  // Target units; bit i of the select is unit i+1
  typedef enum logic [2:0] {
    PRD_U_NONE,
    PRD_U_AUDIO,
    PRD_U_PORT,
    PRD_U_HOST,
    PRD_U_CARD,
    PRD_U_TIMER,
    PRD_U_CLOCK,
    PRD_U_DMA
  } prd_unit_t;

endpackage

// ---- core/prd_addr_decode.sv ----
// Address decoder of one data space: unit and register index.
`timescale 1ns/1ps
module prd_addr_decode (
  // Address of the data space
  input wire logic [15:0] addr_i,
  // Decode result
  output logic win_o,
  output prd_pkg::prd_unit_t unit_o,
  output logic [2:0] idx_o
);

  logic [5:0] off;

  // ==========================================================
  // Span check per unit
  function automatic logic in_span(input logic [5:0] o,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
    in_span = (o >= lo[5:0]) && (o <= hi[5:0]);
  endfunction

  always_comb begin
    off = addr_i[5:0];
    win_o = (addr_i[15:6] == prd_pkg::WIN_TAG);
    unit_o = prd_pkg::PRD_U_NONE;
    idx_o = 3'h0;
    if (win_o) begin
      // RULE2: serial, port, host
      if (in_span(off, prd_pkg::A_SERIAL_DATA,
                  prd_pkg::A_AUDIO_STATUS)) begin
        unit_o = prd_pkg::PRD_U_AUDIO;
        idx_o = 3'(off - prd_pkg::A_SERIAL_DATA[5:0]);
      end else if (in_span(off, prd_pkg::A_PORT_DATA,
                           prd_pkg::A_PORT_CMD)) begin
        unit_o = prd_pkg::PRD_U_PORT;
        idx_o = 3'(off - prd_pkg::A_PORT_DATA[5:0]);
      end else if (in_span(off, prd_pkg::A_HOST_DATA,
                           prd_pkg::A_HOST_STATUS)) begin
        unit_o = prd_pkg::PRD_U_HOST;
        idx_o = 3'(off - prd_pkg::A_HOST_DATA[5:0]);
      // RULE3: card interface registers
      end else if (in_span(off, prd_pkg::A_CARD_DATA,
                           prd_pkg::A_CARD_CRC_BUSY)) begin
        unit_o = prd_pkg::PRD_U_CARD;
        idx_o = 3'(off - prd_pkg::A_CARD_DATA[5:0]);
      // RULE4: timer and clock control
      end else if (in_span(off, prd_pkg::A_TMR_INIT,
                           prd_pkg::A_TMR_ENABLE)) begin
        unit_o = prd_pkg::PRD_U_TIMER;
        idx_o = 3'(off - prd_pkg::A_TMR_INIT[5:0]);
      end else if (off == prd_pkg::A_CLK_CTRL[5:0]) begin
        unit_o = prd_pkg::PRD_U_CLOCK;
      // RULE5: card DMA registers
      end else if (in_span(off, prd_pkg::A_DMA_START,
                           prd_pkg::A_DMA_CTRL)) begin
        unit_o = prd_pkg::PRD_U_DMA;
        idx_o = 3'(off - prd_pkg::A_DMA_START[5:0]);
      end
    end
  end

endmodule // prd_addr_decode

// ---- core/prd_read_mux.sv ----
// Read-data selector over the seven peripheral units.
`timescale 1ns/1ps
module prd_read_mux (
  // Selected unit
  input prd_pkg::prd_unit_t unit_i,
  // Unit read data
  input wire logic [15:0] audio_i,
  input wire logic [15:0] port_i,
  input wire logic [15:0] host_i,
  input wire logic [15:0] card_i,
  input wire logic [15:0] timer_i,
  input wire logic [15:0] clock_i,
  input wire logic [15:0] dma_i,
  // Result
  output logic [15:0] data_o
);

  always_comb begin
    case (unit_i)
      prd_pkg::PRD_U_AUDIO: data_o = audio_i;
      prd_pkg::PRD_U_PORT: data_o = port_i;
      prd_pkg::PRD_U_HOST: data_o = host_i;
      prd_pkg::PRD_U_CARD: data_o = card_i;
      prd_pkg::PRD_U_TIMER: data_o = timer_i;
      prd_pkg::PRD_U_CLOCK: data_o = clock_i;
      prd_pkg::PRD_U_DMA: data_o = dma_i;
      // RULE11: holes read as zero
      default: data_o = prd_pkg::RST_WORD;
    endcase
  end

endmodule // prd_read_mux

// ---- core/prd_decoder.sv ----
// Peripheral register decoder between X/Y data buses and units.
`timescale 1ns/1ps

// Summary of operation
// RULE1: Peripheral registers live in data memory space.
// RULE2: Serial, port and host words at 3800-3807.
// RULE3: Card interface registers at 3810-3816.
// RULE4: Timer 3820-3823, clock control at 382E.
// RULE5: Card DMA registers at 3830-3833.
// RULE6: Software never touches reserved peripheral holes.
// RULE7: X and Y address the same registers.
// RULE8: Never both spaces in one cycle.
// RULE9: Each transfer moves one 16-bit word.
// RULE10: Host data word serves both directions.
// RULE11: Holes select nothing, drop writes, read zero.
module prd_decoder #(
  parameter int DATA_W = prd_pkg::DATA_W,
  parameter int ADDR_W = prd_pkg::ADDR_W
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // X data space
  input wire logic [ADDR_W-1:0] x_addr_i,
  input wire logic x_rd_i,
  input wire logic x_wr_i,
  input wire logic [DATA_W-1:0] x_wdata_i,
  // Y data space
  input wire logic [ADDR_W-1:0] y_addr_i,
  input wire logic y_rd_i,
  input wire logic y_wr_i,
  input wire logic [DATA_W-1:0] y_wdata_i,
  // Answer to the core
  output logic [DATA_W-1:0] rdata_o,
  output logic rvalid_o,
  output logic hole_hit_o,
  output logic xy_clash_o,
  // Request to the units
  output logic [prd_pkg::UNIT_N-1:0] unit_sel_o,
  output logic [prd_pkg::IDX_W-1:0] reg_idx_o,
  output logic unit_wr_o,
  output logic unit_rd_o,
  output logic [DATA_W-1:0] unit_wdata_o,
  // Read data from the units
  input wire logic [DATA_W-1:0] audio_rdata_i,
  input wire logic [DATA_W-1:0] port_rdata_i,
  input wire logic [DATA_W-1:0] host_rdata_i,
  input wire logic [DATA_W-1:0] card_rdata_i,
  input wire logic [DATA_W-1:0] timer_rdata_i,
  input wire logic [DATA_W-1:0] clock_rdata_i,
  input wire logic [DATA_W-1:0] dma_rdata_i
);

  // ==========================================================
  // Elaboration checks
  // The word path is fixed at the core's 16-bit transfer width.
  if (DATA_W != prd_pkg::DATA_W) begin : g_bad_data_w
    $error("DATA_W must be 16");
  end
  if (ADDR_W != prd_pkg::ADDR_W) begin : g_bad_addr_w
    $error("ADDR_W must be 16");
  end

  // ==========================================================
  // Decode of both spaces
  logic x_win;
  logic y_win;
  prd_pkg::prd_unit_t x_unit;
  prd_pkg::prd_unit_t y_unit;
  logic [2:0] x_idx;
  logic [2:0] y_idx;

  // RULE7: one decoder per space, same map
  prd_addr_decode u_dec_x (
    .addr_i(x_addr_i),
    .win_o(x_win),
    .unit_o(x_unit),
    .idx_o(x_idx)
  );

  prd_addr_decode u_dec_y (
    .addr_i(y_addr_i),
    .win_o(y_win),
    .unit_o(y_unit),
    .idx_o(y_idx)
  );

  // ==========================================================
  // Request stage
  logic x_act;
  logic y_act;
  logic req_act;
  logic req_wr;
  logic req_rd;
  prd_pkg::prd_unit_t req_unit;
  logic [2:0] req_idx;
  logic [15:0] req_wdata;

  // A cycle that leaves the peripheral window is ordinary memory.
  assign x_act = x_win && (x_rd_i || x_wr_i);
  assign y_act = y_win && (y_rd_i || y_wr_i);

  always_comb begin
    // RULE8: X wins if software breaks the one-space limit
    if (x_act) begin
      req_wr = x_wr_i;
      req_rd = x_rd_i && !x_wr_i;
      req_unit = x_unit;
      req_idx = x_idx;
      req_wdata = x_wdata_i;
    end else begin
      req_wr = y_wr_i;
      req_rd = y_rd_i && !y_wr_i;
      req_unit = y_unit;
      req_idx = y_idx;
      req_wdata = y_wdata_i;
    end
    req_act = x_act || y_act;
  end

  // ==========================================================
  // Unit request registers
  logic [6:0] sel_reg;
  logic [6:0] sel_next;
  logic [2:0] idx_reg;
  logic [2:0] idx_next;
  logic wr_reg;
  logic wr_next;
  logic rd_reg;
  logic rd_next;
  logic [15:0] wdata_reg;
  logic [15:0] wdata_next;
  logic pend_reg;
  logic pend_next;
  prd_pkg::prd_unit_t punit_reg;
  prd_pkg::prd_unit_t punit_next;
  logic hole_reg;
  logic hole_next;
  logic clash_reg;
  logic clash_next;

  always_comb begin
    sel_next = prd_pkg::RST_SEL;
    idx_next = 3'h0;
    wr_next = 1'b0;
    rd_next = 1'b0;
    wdata_next = wdata_reg;
    pend_next = 1'b0;
    punit_next = prd_pkg::PRD_U_NONE;
    hole_next = 1'b0;
    clash_next = x_act && y_act;
    if (req_act) begin
      // RULE11: a hole starts no unit access
      hole_next = (req_unit == prd_pkg::PRD_U_NONE);
      // RULE1: data-memory access reaches the unit
      if (!hole_next) begin
        for (int i = 0; i < prd_pkg::UNIT_N; i++) begin
          sel_next[i] = (req_unit == prd_pkg::prd_unit_t'(i + 1));
        end
        idx_next = req_idx;
        wr_next = req_wr;
        rd_next = req_rd;
        // RULE9: one whole word per write
        if (req_wr) begin
          wdata_next = req_wdata;
        end
      end
      pend_next = req_rd;
      punit_next = req_unit;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      sel_reg <= prd_pkg::RST_SEL;
      idx_reg <= 3'h0;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      wdata_reg <= prd_pkg::RST_WORD;
      pend_reg <= 1'b0;
      punit_reg <= prd_pkg::PRD_U_NONE;
      hole_reg <= 1'b0;
      clash_reg <= 1'b0;
    end else begin
      sel_reg <= sel_next;
      idx_reg <= idx_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      wdata_reg <= wdata_next;
      pend_reg <= pend_next;
      punit_reg <= punit_next;
      hole_reg <= hole_next;
      clash_reg <= clash_next;
    end
  end

  // ==========================================================
  // Read return
  logic [15:0] mux_data;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;

  // RULE10: host data word read in the same slot as written
  prd_read_mux u_rmux (
    .unit_i(punit_reg),
    .audio_i(audio_rdata_i),
    .port_i(port_rdata_i),
    .host_i(host_rdata_i),
    .card_i(card_rdata_i),
    .timer_i(timer_rdata_i),
    .clock_i(clock_rdata_i),
    .dma_i(dma_rdata_i),
    .data_o(mux_data)
  );

  always_comb begin
    rvalid_next = pend_reg;
    rdata_next = rdata_reg;
    // RULE9: one word returned per read
    if (pend_reg) begin
      rdata_next = mux_data;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      rdata_reg <= prd_pkg::RST_WORD;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign rdata_o = rdata_reg;
  assign rvalid_o = rvalid_reg;
  assign hole_hit_o = hole_reg;
  assign xy_clash_o = clash_reg;
  assign unit_sel_o = sel_reg;
  assign reg_idx_o = idx_reg;
  assign unit_wr_o = wr_reg;
  assign unit_rd_o = rd_reg;
  assign unit_wdata_o = wdata_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  a_write_reaches: assert property ( // RULE1
    (x_act && x_wr_i && x_unit != prd_pkg::PRD_U_NONE)
    |=> (unit_wr_o && unit_sel_o != 7'h00
         && unit_wdata_o == $past(x_wdata_i)))
    else $error("write did not reach a unit");

  a_serial_map: assert property ( // RULE2
    (x_act && x_addr_i == prd_pkg::A_SERIAL_DATA)
    |=> (unit_sel_o == 7'h01 && reg_idx_o == 3'h0))
    else $error("serial data word misrouted");

  a_card_map: assert property ( // RULE3
    (x_act && x_addr_i == prd_pkg::A_CARD_CRC_BUSY)
    |=> (unit_sel_o == 7'h08 && reg_idx_o == 3'h6))
    else $error("card status word misrouted");

  a_clock_map: assert property ( // RULE4
    (!x_act && y_act && y_addr_i == prd_pkg::A_CLK_CTRL)
    |=> (unit_sel_o == 7'h20 && reg_idx_o == 3'h0))
    else $error("clock control misrouted");

  a_dma_map: assert property ( // RULE5
    (!x_act && y_act && y_addr_i == prd_pkg::A_DMA_CTRL)
    |=> (unit_sel_o == 7'h40 && reg_idx_o == 3'h3))
    else $error("dma control misrouted");

  a_space_alias: assert property ( // RULE7
    (x_addr_i == y_addr_i)
    |-> (x_unit == y_unit && x_idx == y_idx))
    else $error("X and Y decode differ");

  a_single_target: assert property ( // RULE8
    $onehot0(unit_sel_o))
    else $error("more than one unit selected");

  a_clash_flag: assert property ( // RULE8
    (x_act && y_act) |=> xy_clash_o)
    else $error("clash of both spaces not flagged");

  a_host_read: assert property ( // RULE10
    (unit_rd_o && unit_sel_o == 7'h04)
    |=> (rvalid_o && rdata_o == $past(host_rdata_i)))
    else $error("host read data not returned");

  a_hole_zero: assert property ( // RULE11
    (req_act && req_rd && req_unit == prd_pkg::PRD_U_NONE)
    |=> (unit_sel_o == 7'h00 && !unit_rd_o && hole_hit_o)
    ##1 (rvalid_o && rdata_o == 16'h0000))
    else $error("hole read not zero");

  a_read_latency: assert property ( // RULE9
    (req_act && req_rd) |=> (unit_rd_o || hole_hit_o) ##1 rvalid_o)
    else $error("read answer not two cycles later");

endmodule // prd_decoder

// ---- verif/prd_unit_model.sv ----
// Register model of the seven peripheral units behind the decoder.
`timescale 1ns/1ps
module prd_unit_model (
  // Clock
  input wire logic mclk_i,
  // Request from the decoder
  input wire logic [6:0] unit_sel_i,
  input wire logic [2:0] reg_idx_i,
  input wire logic unit_wr_i,
  input wire logic [15:0] unit_wdata_i,
  // Read data towards the decoder
  output logic [15:0] rdata_o [7]
);
  logic [15:0] mem_reg [7][8];
  logic [15:0] junk_reg = 16'h5A5A;

  // ==========================================================
  // Storage
  // one word per access
  always_ff @(posedge mclk_i) begin
    junk_reg <= ~junk_reg + 16'h0001;
    for (int u = 0; u < 7; u++) begin
      if (unit_wr_i && unit_sel_i[u]) begin
        mem_reg[u][reg_idx_i] <= unit_wdata_i;
      end
    end
  end

  // ==========================================================
  // Read path
  // An unselected unit shows a moving pattern, so a decoder that
  // picks the wrong source can never match by luck.
  always_comb begin
    for (int u = 0; u < 7; u++) begin
      rdata_o[u] = unit_sel_i[u] ? mem_reg[u][reg_idx_i] : junk_reg;
    end
  end
endmodule // prd_unit_model

// ---- verif/prd_decoder_tb_top.sv ----
// Self-checking testbench of the peripheral register decoder.
`timescale 1ns/1ps
module prd_decoder_tb_top;
  typedef struct packed {
    logic [15:0] base;
    logic [2:0] cnt;
  } prd_row_t;

  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [15:0] x_addr_i = 16'h0000;
  logic x_rd_i = 1'b0;
  logic x_wr_i = 1'b0;
  logic [15:0] x_wdata_i = 16'h0000;
  logic [15:0] y_addr_i = 16'h0000;
  logic y_rd_i = 1'b0;
  logic y_wr_i = 1'b0;
  logic [15:0] y_wdata_i = 16'h0000;
  logic [15:0] rdata_o;
  logic rvalid_o;
  logic hole_hit_o;
  logic xy_clash_o;
  logic [6:0] unit_sel_o;
  logic [2:0] reg_idx_o;
  logic unit_wr_o;
  logic unit_rd_o;
  logic [15:0] unit_wdata_o;
  logic [15:0] urd [7];
  logic [15:0] flags;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;

  // ==========================================================
  // Unit table and reserved holes
  // first address and size of each unit
  prd_row_t rows [7] = '{'{16'h3800, 3'h3}, '{16'h3804, 3'h2},
    '{16'h3806, 3'h2}, '{16'h3810, 3'h7}, '{16'h3820, 3'h4},
    '{16'h382E, 3'h1}, '{16'h3830, 3'h4}};
  logic [15:0] holes [10] = '{16'h3803, 16'h3808, 16'h380F, 16'h3817,
    16'h381F, 16'h3824, 16'h382D, 16'h382F, 16'h3834, 16'h383F};

  // Bits: 11 rvalid, 10 hole, 9 clash, 8 wr, 7 rd, 6..0 select.
  assign flags = {4'h0, rvalid_o, hole_hit_o, xy_clash_o, unit_wr_o,
    unit_rd_o, unit_sel_o};

  always #2 mclk_i = ~mclk_i;

  prd_decoder uut (
    .mclk_i(mclk_i), .rstn_i(rstn_i),
    .x_addr_i(x_addr_i), .x_rd_i(x_rd_i), .x_wr_i(x_wr_i),
    .x_wdata_i(x_wdata_i),
    .y_addr_i(y_addr_i), .y_rd_i(y_rd_i), .y_wr_i(y_wr_i),
    .y_wdata_i(y_wdata_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .hole_hit_o(hole_hit_o),
    .xy_clash_o(xy_clash_o), .unit_sel_o(unit_sel_o),
    .reg_idx_o(reg_idx_o), .unit_wr_o(unit_wr_o), .unit_rd_o(unit_rd_o),
    .unit_wdata_o(unit_wdata_o),
    .audio_rdata_i(urd[0]), .port_rdata_i(urd[1]), .host_rdata_i(urd[2]),
    .card_rdata_i(urd[3]), .timer_rdata_i(urd[4]),
    .clock_rdata_i(urd[5]), .dma_rdata_i(urd[6])
  );

  prd_unit_model units (
    .mclk_i(mclk_i), .unit_sel_i(unit_sel_o), .reg_idx_i(reg_idx_o),
    .unit_wr_i(unit_wr_o), .unit_wdata_i(unit_wdata_o), .rdata_o(urd)
  );

  // ==========================================================
  // Shared tasks
  task automatic summarize();
    if (failures == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Op codes: bit 1 write, bit 0 read.
  task automatic go(input logic [15:0] xa, input logic [1:0] xo,
                    input logic [15:0] ya, input logic [1:0] yo,
                    input logic [15:0] d);
    @(posedge mclk_i);
    x_addr_i <= xa;
    {x_wr_i, x_rd_i} <= xo;
    y_addr_i <= ya;
    {y_wr_i, y_rd_i} <= yo;
    x_wdata_i <= d;
    y_wdata_i <= d;
  endtask

  // The request is taken here; results are looked at mid-cycle.
  task automatic tk();
    @(posedge mclk_i);
    {x_wr_i, x_rd_i, y_wr_i, y_rd_i} <= 4'h0;
    @(negedge mclk_i);
  endtask

  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      failures++;
      summarize();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [15:0] a;
    logic [15:0] d;
    logic sp;
    repeat (16) @(posedge mclk_i);
    rstn_i <= 1'b1;
    @(negedge mclk_i);
    chk(flags, 16'h0000);
    chk(rdata_o, 16'h0000);
    // Each register is written on one space and read on the other.
    for (int u = 0; u < 7; u++) begin
      for (int i = 0; i < int'(rows[u].cnt); i++) begin
        a = rows[u].base + 16'(i);
        d = a ^ 16'hC35A;
        sp = 1'(u + i);
        if (sp) go(16'h0000, 2'h0, a, 2'h2, d);
        else go(a, 2'h2, 16'h0000, 2'h0, d);
        tk();
        chk(flags, 16'h0100 | 16'(1 << u));
        chk(16'(reg_idx_o), 16'(i));
        chk(unit_wdata_o, d);
        if (sp) go(a, 2'h1, 16'h0000, 2'h0, 16'h0000);
        else go(16'h0000, 2'h0, a, 2'h1, 16'h0000);
        tk();
        chk(flags, 16'h0080 | 16'(1 << u));
        @(negedge mclk_i);
        chk(flags, 16'h0800);
        chk(rdata_o, d);
      end
    end
    foreach (holes[h]) begin
      go(holes[h], 2'h2, 16'h0000, 2'h0, 16'hFFFF);
      tk();
      chk(flags, 16'h0400);
      chk(unit_wdata_o, d);
      go(16'h0000, 2'h0, holes[h], 2'h1, 16'h0000);
      tk();
      chk(flags, 16'h0400);
      @(negedge mclk_i);
      chk(flags, 16'h0800);
      chk(rdata_o, 16'h0000);
    end
    go(16'h37FF, 2'h1, 16'h3840, 2'h2, 16'h0001);
    tk();
    chk(flags, 16'h0000);
    @(negedge mclk_i);
    chk(flags, 16'h0000);
    // Both spaces at once: X is served and the Y write is lost.
    go(16'h3806, 2'h1, 16'h3820, 2'h2, 16'h1234);
    tk();
    chk(flags, 16'h0284);
    @(negedge mclk_i);
    chk(rdata_o, 16'h3806 ^ 16'hC35A);
    go(16'h0000, 2'h0, 16'h3820, 2'h1, 16'h0000);
    tk();
    @(negedge mclk_i);
    chk(rdata_o, 16'h3820 ^ 16'hC35A);
    // Write and read of one register in back-to-back cycles.
    go(16'h382E, 2'h2, 16'h0000, 2'h0, 16'hBEEF);
    go(16'h0000, 2'h0, 16'h382E, 2'h1, 16'h0000);
    tk();
    chk(flags, 16'h00A0);
    @(negedge mclk_i);
    chk(rdata_o, 16'hBEEF);
    // Two reads in a row are answered in consecutive cycles.
    go(16'h3800, 2'h1, 16'h0000, 2'h0, 16'h0000);
    go(16'h3801, 2'h1, 16'h0000, 2'h0, 16'h0000);
    tk();
    chk(flags, 16'h0881);
    chk(rdata_o, 16'h3800 ^ 16'hC35A);
    @(negedge mclk_i);
    chk(flags, 16'h0800);
    chk(rdata_o, 16'h3801 ^ 16'hC35A);
    // Reset lands between a read's strobe and its answer.
    go(16'h3821, 2'h1, 16'h0000, 2'h0, 16'h0000);
    @(posedge mclk_i);
    rstn_i <= 1'b0;
    {x_wr_i, x_rd_i} <= 2'h0;
    @(negedge mclk_i);
    chk(flags, 16'h0090);
    @(negedge mclk_i);
    chk(flags, 16'h0000);
    chk(rdata_o, 16'h0000);
    @(posedge mclk_i);
    rstn_i <= 1'b1;
    go(16'h0000, 2'h0, 16'h3821, 2'h1, 16'h0000);
    tk();
    @(negedge mclk_i);
    chk(rdata_o, 16'h3821 ^ 16'hC35A);
    summarize();
  end
endmodule // prd_decoder_tb_top
